/* File: logic/status_event_consts.vh */
// Constants for the common-command status and event core
// Notes on behaviour
// - Eight-bit event latch, bits 0,2,3,4,5 used
// - Event enable mask stored, read back 0-255
// - Event latch query returns value, then clears
// - Operation-complete command sets bit 0 when idle
// - Operation-complete query waits idle, answers 1
// - Identity query picks user or preset string
// - Recall restores setup from slot 1-10
// - Save writes present setup to slot 1-10
// - Slot outside 1-10 rejected, error -222
// - Reset command returns settings to preset
// - Service request mask stored, read back 0-191, bit 6 zero
// - Service mask bit 6 forced zero
// - Status byte bit 6 is service summary
`ifndef STATUS_EVENT_CONSTS_VH
`define STATUS_EVENT_CONSTS_VH
`define CMD_NONE 4'h0
`define CMD_ESE_SET 4'h1
`define CMD_ESE_QRY 4'h2
`define CMD_ESR_QRY 4'h3
`define CMD_OPC_SET 4'h4
`define CMD_OPC_QRY 4'h5
`define CMD_IDN_QRY 4'h6
`define CMD_RCL 4'h7
`define CMD_SAV 4'h8
`define CMD_RST 4'h9
`define CMD_SRE_SET 4'ha
`define CMD_SRE_QRY 4'hb
`define CMD_STB_QRY 4'hc
`define CMD_CLS 4'hd
`define EV_OPC 0
`define EV_QUERY_ERR 2
`define EV_DEV_ERR 3
`define EV_EXEC_ERR 4
`define EV_CMD_ERR 5
`define EV_USED_MASK 8'h3d
`define SB_EVENT_SUM 5
`define SB_SERVICE_SUM 6
`define SB_SOURCE_MASK 8'h9e
`define SRE_BIT6_CLEAR 8'hbf
`define SLOT_MIN 8'h01
`define SLOT_MAX 8'h0a
`define ERR_OUT_OF_RANGE 16'hff22
`define ERR_NONE 16'h0000
`define OPC_ANSWER 8'h01
`define RESET_BYTE 8'h00
`define IDN_PRESET 2'h0
`define IDN_USER 2'h1
`endif

/* File: logic/ieee488_status_event_core.v */
// Common-command status, event, save and recall core
`timescale 1ns/10ps
`include "status_event_consts.vh"
module ieee488_status_event_core #(
   parameter SETUP_W = 32,
   parameter SLOTS = 10
) (
   input wire i_sys_clk, // 40 MHz clock
   input wire i_reset_n, // Synchronous reset, active low
   input wire i_cmd_valid, // One-cycle command strobe
   input wire [3:0] i_cmd_code, // Decoded common command
   input wire [7:0] i_cmd_arg, // Integer argument
   input wire i_cmd_unknown, // Header not recognised
   input wire i_param_bad, // Parameter cannot be executed
   input wire i_query_err, // Query error event
   input wire i_dev_err, // Device-dependent error event
   input wire i_ops_pending, // Some operation still running
   input wire [7:0] i_summary_bits, // Bits 1,2,3,4,7 of status byte
   input wire i_user_identity_select, // User identity string on
   input wire [SETUP_W-1:0] i_setup, // Present instrument setup
   input wire [SETUP_W-1:0] i_preset_setup, // Preset setup
   output reg o_resp_valid, // One-cycle query answer strobe
   output reg [7:0] o_resp_data, // Query answer integer
   output reg o_idn_valid, // One-cycle identity answer strobe
   output reg [1:0] o_idn_source, // 0 preset, 1 user string
   output reg o_setup_load, // One-cycle setup load strobe
   output reg [SETUP_W-1:0] o_setup, // Setup to load
   output reg o_err_valid, // One-cycle error queue push
   output reg [15:0] o_err_code, // Error code, two's complement
   output reg [7:0] o_status_byte, // Live status byte
   output reg o_busy // Waiting on operation-complete query
);
   // Event latch and the two masks
   reg [7:0] event_status_latch_q;
   reg [7:0] event_status_latch_d;
   reg [7:0] event_status_mask_q;
   reg [7:0] event_status_mask_d;
   reg [7:0] service_request_mask_q;
   reg [7:0] service_request_mask_d;
   reg opc_armed_q;
   reg opc_armed_d;
   reg opc_query_q;
   reg opc_query_d;
   // Slots keep their setup across reset, as stored setups should
   reg [SETUP_W-1:0] slot_mem [0:SLOTS-1];
   // Next values of the registered outputs
   reg resp_valid_d;
   reg [7:0] resp_data_d;
   reg idn_valid_d;
   reg [1:0] idn_source_d;
   reg setup_load_d;
   reg [SETUP_W-1:0] setup_d;
   reg err_valid_d;
   reg [15:0] err_code_d;
   reg busy_d;
   reg [7:0] ev_set;
   reg [7:0] sb_d;

   // True for the two commands that carry a slot number
   function slot_cmd;
      input [3:0] c;
      begin
         slot_cmd = (c == `CMD_RCL) || (c == `CMD_SAV);
      end
   endfunction

   function slot_in_range;
      input [7:0] n;
      begin
         slot_in_range = (n >= `SLOT_MIN) && (n <= `SLOT_MAX);
      end
   endfunction

   // Unused latch bits can never be set
   function [7:0] used_events;
      input [7:0] v;
      begin
         used_events = v & `EV_USED_MASK;
      end
   endfunction

   // Bits 5 and 6 are built here, never taken from outside
   function [7:0] sb_sources;
      input [7:0] v;
      begin
         sb_sources = v & `SB_SOURCE_MASK;
      end
   endfunction

   wire cmd = i_cmd_valid & ~o_busy;
   // Unknown header or bad parameter: only the event bit is raised
   wire act = cmd & ~i_cmd_unknown & ~i_param_bad;
   wire slot_ok = slot_in_range(i_cmd_arg);
   wire [7:0] slot_off = i_cmd_arg - `SLOT_MIN;
   wire [3:0] slot_idx = slot_off[3:0];
   wire opc_done = ~i_ops_pending;
   wire opc_fire = opc_armed_q & opc_done;
   wire opc_answer = opc_query_q & opc_done;
   wire save_go = act && (i_cmd_code == `CMD_SAV) && slot_ok;
   wire range_bad = act && slot_cmd(i_cmd_code) && !slot_ok;

   always @*
   begin
      ev_set = `RESET_BYTE;
      ev_set[`EV_QUERY_ERR] = i_query_err;
      ev_set[`EV_DEV_ERR] = i_dev_err;
      // Header errors count even while a query is held
      ev_set[`EV_CMD_ERR] = i_cmd_valid & i_cmd_unknown;
      ev_set[`EV_EXEC_ERR] = cmd & i_param_bad;
      ev_set[`EV_OPC] = opc_fire;
   end

   always @*
   begin
      sb_d = sb_sources(i_summary_bits);
      sb_d[`SB_EVENT_SUM] = |(event_status_latch_q & event_status_mask_q);
      sb_d[`SB_SERVICE_SUM] = |(sb_d & service_request_mask_q);
   end

   // Set wins over the query clear, so no event is lost
   always @*
   begin
      event_status_latch_d = used_events(event_status_latch_q | ev_set);
      if (act && ((i_cmd_code == `CMD_ESR_QRY) || (i_cmd_code == `CMD_CLS)))
      begin
         event_status_latch_d = used_events(ev_set);
      end
   end

   always @*
   begin
      event_status_mask_d = event_status_mask_q;
      service_request_mask_d = service_request_mask_q;
      if (act && (i_cmd_code == `CMD_ESE_SET))
      begin
         event_status_mask_d = i_cmd_arg;
      end
      if (act && (i_cmd_code == `CMD_SRE_SET))
      begin
         // Bit 6 is the summary itself and cannot be enabled
         service_request_mask_d = i_cmd_arg & `SRE_BIT6_CLEAR;
      end
   end

   always @*
   begin
      opc_armed_d = opc_armed_q & ~opc_fire;
      opc_query_d = opc_query_q & ~opc_answer;
      busy_d = o_busy & ~opc_answer;
      if (act && (i_cmd_code == `CMD_OPC_SET))
      begin
         opc_armed_d = 1'b1;
      end
      if (act && (i_cmd_code == `CMD_CLS))
      begin
         opc_armed_d = 1'b0;
      end
      if (act && (i_cmd_code == `CMD_OPC_QRY))
      begin
         // Commands arriving before the answer are dropped
         opc_query_d = 1'b1;
         busy_d = 1'b1;
      end
   end

   always @*
   begin
      resp_valid_d = 1'b0;
      resp_data_d = o_resp_data;
      idn_valid_d = 1'b0;
      idn_source_d = o_idn_source;
      setup_load_d = 1'b0;
      setup_d = o_setup;
      if (opc_answer)
      begin
         resp_valid_d = 1'b1;
         resp_data_d = `OPC_ANSWER;
      end
      if (act)
      begin
         case (i_cmd_code)
            `CMD_ESE_QRY:
            begin
               resp_valid_d = 1'b1;
               resp_data_d = event_status_mask_q;
            end
            `CMD_ESR_QRY:
            begin
               resp_valid_d = 1'b1;
               resp_data_d = event_status_latch_q;
            end
            `CMD_SRE_QRY:
            begin
               resp_valid_d = 1'b1;
               resp_data_d = service_request_mask_q;
            end
            `CMD_STB_QRY:
            begin
               resp_valid_d = 1'b1;
               resp_data_d = sb_d;
            end
            `CMD_IDN_QRY:
            begin
               idn_valid_d = 1'b1;
               idn_source_d = i_user_identity_select ? `IDN_USER : `IDN_PRESET;
            end
            `CMD_RCL:
            begin
               if (slot_ok)
               begin
                  setup_load_d = 1'b1;
                  setup_d = slot_mem[slot_idx];
               end
            end
            `CMD_RST:
            begin
               setup_load_d = 1'b1;
               setup_d = i_preset_setup;
            end
            default:
            begin
            end
         endcase
      end
   end

   always @*
   begin
      err_valid_d = 1'b0;
      err_code_d = o_err_code;
      if (range_bad)
      begin
         err_valid_d = 1'b1;
         err_code_d = `ERR_OUT_OF_RANGE;
      end
   end

   always @(posedge i_sys_clk)
   begin
      if (save_go)
      begin
         slot_mem[slot_idx] <= i_setup;
      end
   end

   // Internal state
   always @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         event_status_latch_q <= `RESET_BYTE;
         event_status_mask_q <= `RESET_BYTE;
         service_request_mask_q <= `RESET_BYTE;
         opc_armed_q <= 1'b0;
         opc_query_q <= 1'b0;
      end
      else
      begin
         event_status_latch_q <= event_status_latch_d;
         event_status_mask_q <= event_status_mask_d;
         service_request_mask_q <= service_request_mask_d;
         opc_armed_q <= opc_armed_d;
         opc_query_q <= opc_query_d;
      end
   end

   always @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         o_resp_valid <= 1'b0;
         o_resp_data <= `RESET_BYTE;
         o_idn_valid <= 1'b0;
         o_idn_source <= `IDN_PRESET;
         o_setup_load <= 1'b0;
         o_setup <= {SETUP_W{1'b0}};
         o_err_valid <= 1'b0;
         o_err_code <= `ERR_NONE;
      end
      else
      begin
         o_resp_valid <= resp_valid_d;
         o_resp_data <= resp_data_d;
         o_idn_valid <= idn_valid_d;
         o_idn_source <= idn_source_d;
         o_setup_load <= setup_load_d;
         o_setup <= setup_d;
         o_err_valid <= err_valid_d;
         o_err_code <= err_code_d;
      end
   end

   // Status byte lags the latch by one cycle
   always @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         o_status_byte <= `RESET_BYTE;
         o_busy <= 1'b0;
      end
      else
      begin
         o_status_byte <= sb_d;
         o_busy <= busy_d;
      end
   end
endmodule // ieee488_status_event_core

/* File: sim/status_event_checker.sv */
// Concurrent checks on the status and event core ports
`timescale 1ns/10ps
`include "status_event_consts.vh"
module status_event_checker (
   input wire i_sys_clk, // Clock
   input wire i_reset_n, // Reset
   input wire i_cmd_valid, // Strobe
   input wire [3:0] i_cmd_code, // Code
   input wire [7:0] i_cmd_arg, // Argument
   input wire i_cmd_unknown, // Bad header
   input wire i_param_bad, // Bad parameter
   input wire i_ops_pending, // Pending
   input wire i_user_identity_select, // Identity pick
   input wire o_resp_valid, // Answer
   input wire [7:0] o_resp_data, // Answer data
   input wire o_idn_valid, // Identity answer
   input wire [1:0] o_idn_source, // Identity source
   input wire o_setup_load, // Load
   input wire o_err_valid, // Error push
   input wire [15:0] o_err_code, // Error code
   input wire o_busy // Waiting
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   wire take = i_cmd_valid && !o_busy && !i_cmd_unknown && !i_param_bad;
   wire slot_ok = i_cmd_arg >= `SLOT_MIN && i_cmd_arg <= `SLOT_MAX;
   wire slot_cmd = i_cmd_code == `CMD_SAV || i_cmd_code == `CMD_RCL;
   a_opc_query_wait: assert property (take && i_cmd_code == `CMD_OPC_QRY && i_ops_pending |=> o_busy && !o_resp_valid)
      else $error("opc query did not wait");
   a_opc_answer_one: assert property ($fell(o_busy) |-> o_resp_valid && o_resp_data == `OPC_ANSWER)
      else $error("opc answer wrong");
   a_slot_range_err: assert property (take && slot_cmd && !slot_ok |=> o_err_valid && o_err_code == `ERR_OUT_OF_RANGE && !o_setup_load)
      else $error("slot range error missing");
   a_recall_loads: assert property (take && i_cmd_code == `CMD_RCL && slot_ok |=> o_setup_load && !o_err_valid)
      else $error("recall did not load");
   a_idn_source: assert property (take && i_cmd_code == `CMD_IDN_QRY |=> o_idn_valid && o_idn_source == {1'b0, $past(i_user_identity_select)})
      else $error("identity source wrong");
   a_esr_unused_zero: assert property (take && i_cmd_code == `CMD_ESR_QRY |=> o_resp_valid && (o_resp_data & 8'hc2) == 8'h00)
      else $error("event latch unused bits set");
   a_unknown_inert: assert property (i_cmd_valid && i_cmd_unknown |=> !o_resp_valid && !o_idn_valid && !o_setup_load && !o_err_valid)
      else $error("unknown header acted");
   a_reset_loads: assert property (take && i_cmd_code == `CMD_RST |=> o_setup_load && !o_err_valid)
      else $error("reset did not load preset");
endmodule // status_event_checker
bind ieee488_status_event_core status_event_checker i_status_event_checker (.*);

/* File: sim/host_model.sv */
// Host side issuing common commands
`timescale 1ns/10ps
module host_model (
   input wire i_sys_clk, // Clock
   output reg o_cmd_valid, // Strobe
   output reg [3:0] o_cmd_code, // Code
   output reg [7:0] o_cmd_arg, // Argument
   output reg o_cmd_unknown, // Bad header
   output reg o_param_bad // Bad parameter
);
   initial {o_cmd_valid, o_cmd_code, o_cmd_arg, o_cmd_unknown, o_param_bad} = 15'h0;
   task send(input [3:0] c, input [7:0] a, input u, input p);
      begin
         {o_cmd_valid, o_cmd_code, o_cmd_arg, o_cmd_unknown, o_param_bad} = {1'b1, c, a, u, p};
         @(posedge i_sys_clk);
         #1;
      end
   endtask
   task idle;
      begin
         {o_cmd_valid, o_cmd_unknown, o_param_bad} = 3'h0;
         o_cmd_arg = ~o_cmd_arg; // Stale argument must not be trusted
         @(posedge i_sys_clk);
         #1;
      end
   endtask
endmodule // host_model

/* File: sim/ieee488_status_event_core_bench.sv */
// Self-checking bench for the status and event core
`timescale 1ns/10ps
`include "status_event_consts.vh"
module ieee488_status_event_core_bench;
   reg i_sys_clk = 0, i_reset_n = 0, i_query_err = 0, i_dev_err = 0, i_ops_pending = 0, i_user_identity_select = 0;
   reg [7:0] i_summary_bits = 0, m;
   reg [31:0] i_setup = 0, i_preset_setup = 0, seed = 32'h17a1762e;
   reg [31:0] slot [0:11];
   reg [35:0] q [$];
   reg [35:0] e;
   integer n_mismatch = 0, checked = 0, i;
   wire i_cmd_valid, i_cmd_unknown, i_param_bad, o_resp_valid, o_idn_valid, o_setup_load, o_err_valid, o_busy;
   wire [3:0] i_cmd_code;
   wire [7:0] i_cmd_arg, o_resp_data, o_status_byte;
   wire [1:0] o_idn_source;
   wire [31:0] o_setup;
   wire [15:0] o_err_code;
   initial forever #12.5 i_sys_clk = ~i_sys_clk;
   host_model i_host_model (.i_sys_clk(i_sys_clk), .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code),
      .o_cmd_arg(i_cmd_arg), .o_cmd_unknown(i_cmd_unknown), .o_param_bad(i_param_bad));
   ieee488_status_event_core i_ieee488_status_event_core (.*);
   function [35:0] k(input [3:0] t, input [31:0] v);
      k = {t, v};
   endfunction
   task chk(input [35:0] s, input [35:0] x);
      begin
         checked = checked + 1;
         if (s !== x)
         begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
         end
      end
   endtask
   task pop(input [35:0] s);
      begin
         e = 36'hx;
         if (q.size() > 0)
            e = q.pop_front();
         chk(s, e);
      end
   endtask
   task tx(input [3:0] c, input [7:0] a, input [35:0] x);
      begin
         if (x[35:32] != 4'h0)
            q.push_back(x);
         i_host_model.send(c, a, 1'b0, 1'b0);
         i_host_model.idle;
      end
   endtask
   task complete_run;
      begin
         $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
         if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   always @(posedge i_sys_clk)
   begin
      #2;
      if (o_resp_valid === 1'b1)
         pop(k(1, o_resp_data));
      if (o_idn_valid === 1'b1)
         pop(k(2, o_idn_source));
      if (o_setup_load === 1'b1)
         pop(k(3, o_setup));
      if (o_err_valid === 1'b1)
         pop(k(4, o_err_code));
   end
   initial
   begin
      #100000;
      n_mismatch = n_mismatch + 1;
      complete_run;
   end
   initial
   begin
      repeat (20) @(posedge i_sys_clk);
      #1;
      i_reset_n = 1;
      m = $random(seed);
      tx(`CMD_ESE_SET, m, 0);
      tx(`CMD_ESE_QRY, 0, k(1, m));
      tx(`CMD_ESE_SET, 8'h3c, 0);
      tx(`CMD_SRE_SET, 8'hff, 0);
      tx(`CMD_SRE_QRY, 0, k(1, 8'hbf));
      tx(`CMD_SRE_SET, 8'hbc, 0);
      tx(`CMD_SRE_QRY, 0, k(1, 8'hbc));
      i_summary_bits = $random(seed);
      {i_query_err, i_dev_err} = 2'h3;
      i_host_model.send(`CMD_RST, 0, 1'b1, 1'b0);
      {i_query_err, i_dev_err} = 2'h0;
      i_host_model.send(`CMD_SAV, 8'h03, 1'b0, 1'b1);
      i_host_model.idle;
      tx(`CMD_STB_QRY, 0, k(1, i_summary_bits & 8'h9e | 8'h60));
      chk(o_status_byte, i_summary_bits & 8'h9e | 8'h60);
      tx(`CMD_ESR_QRY, 0, k(1, 8'h3c));
      tx(`CMD_ESR_QRY, 0, k(1, 0));
      i_ops_pending = 1;
      tx(`CMD_OPC_SET, 0, 0);
      #100;
      tx(`CMD_ESR_QRY, 0, k(1, 0));
      i_ops_pending = 0;
      #100;
      tx(`CMD_ESR_QRY, 0, k(1, 1));
      i_ops_pending = 1;
      tx(`CMD_OPC_QRY, 0, k(1, 1));
      tx(`CMD_SRE_QRY, 0, 0);
      #200;
      i_ops_pending = 0;
      #100;
      i_dev_err = 1;
      i_host_model.idle;
      i_dev_err = 0;
      tx(`CMD_CLS, 0, 0);
      tx(`CMD_ESR_QRY, 0, k(1, 0));
      for (i = 0; i < 12; i = i + 1)
      begin
         i_user_identity_select = i[0];
         slot[i] = $random(seed);
         i_setup = slot[i];
         if (i < 2)
            tx(`CMD_IDN_QRY, 0, k(2, i[0]));
         tx(`CMD_SAV, i[7:0], (i == 0 || i == 11) ? k(4, `ERR_OUT_OF_RANGE) : 0);
      end
      for (i = 11; i >= 0; i = i - 1)
         tx(`CMD_RCL, i[7:0], (i == 0 || i == 11) ? k(4, `ERR_OUT_OF_RANGE) : k(3, slot[i]));
      i_preset_setup = $random(seed);
      tx(`CMD_RST, 0, k(3, i_preset_setup));
      #100;
      chk(q.size(), 0);
      complete_run;
   end
endmodule // ieee488_status_event_core_bench
